// ### fes_sequencer.sv
// Fetch/execute sequencer top: acquisition, execution, add and jump,
// and external loading. Assumes a memory that presents read data the
// cycle after mem_rd_o and an arithmetic section with the accumulator.
`timescale 1ns/1ps
`include "fes_params.svh"

// How it works
// RULE1 - Each instruction: acquisition, then execution.
// RULE2 - Acquired once opcode and operand address loaded.
// RULE3 - Acquisition starts copying PC to address register.
// RULE4 - Opcode read into exchange, then opcode register.
// RULE5 - Address register plus one reaches operand word.
// RULE6 - Operand address via exchange into address register.
// RULE7 - PC advances to next sequential instruction.
// RULE8 - Add fetches operand word, adder sums into accumulator.
// RULE9 - Execution end returns automatically to acquisition.
// RULE10 - Loading generates storage addresses internally.
// RULE11 - Loading continues until all words received.
// RULE12 - Every word passes through exchange register.
// RULE13 - Decoder knows 30 instructions: 24 plus 6.
// RULE14 - Flag zero in acquisition blocks opcode decode.
// RULE15 - Opcode register holds six-bit instruction code.
// RULE16 - Phase counter 0..17 octal, then flag toggles.
// RULE17 - Reset gives acquisition, flag clear, count zero.
// RULE18 - Opcode even address, operand address odd.
module fes_sequencer #(
	parameter int unsigned T0_CYC = `FES_T0_CYC
) (
	// Clock and reset.
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// Memory section.
	output logic [5:0]      mem_addr_o,
	output logic            mem_rd_o,
	output logic            mem_wr_o,
	output logic [5:0]      mem_wdata_o,
	input  wire logic [5:0] mem_rdata_i,
	// Arithmetic section.
	output logic            add_o,
	output logic [5:0]      xchg_o,
	// Decoded command for the other sections.
	output logic            ae_o,
	output logic [5:0]      opcode_o,
	output logic            cmd_valid_o,
	output logic [4:0]      cmd_idx_o,
	output logic [3:0]      step_o,
	// External load input.
	input  wire logic       load_valid_i,
	input  wire logic [5:0] load_data_i,
	input  wire logic       load_last_i,
	output logic            load_ready_o
);

	fes_phase_if ph ();

	fes_phase #(.T0_CYC(T0_CYC)) u_phase (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.ph    (ph.seq)
	);

	fes_pkg::fes_word_t  pc_reg, pc_next;
	fes_pkg::fes_word_t  ma_reg, ma_next;
	fes_pkg::fes_word_t  x_reg, x_next;
	fes_pkg::fes_word_t  opc_reg, opc_next; // Six bits wide. [RULE15]
	logic                ae_reg, ae_next;
	logic                add_reg, add_next;
	logic                rd_pend_reg, rd_pend_next;
	logic                last_reg, last_next;
	fes_pkg::fes_state_t st_reg, st_next;
	fes_pkg::fes_cmd_t   cmd;
	logic                acq_t0;
	logic                ex_t0;

	// Maps an opcode to a command index: even basic codes first, then
	// the odd variants; anything else is not an instruction.
	function automatic fes_pkg::fes_cmd_t decode(input logic [5:0] op);
		fes_pkg::fes_cmd_t r;
		r = '0;
		if (!op[0] && (op[5:1] < `FES_N_BASIC)) begin
			r.valid = 1'b1; // [RULE13]
			r.idx = op[5:1];
		end else if (op[0] && (op[5:1] < `FES_N_VARIANT)) begin
			r.valid = 1'b1; // [RULE13]
			r.idx = `FES_N_BASIC + op[5:1];
		end
		return r;
	endfunction

	// Decode is gated by the flag so a stale opcode cannot act early.
	always_comb begin
		cmd = decode(opc_reg);
		cmd.valid = cmd.valid && ae_reg; // [RULE14]
		acq_t0 = ph.t0 && !ae_reg;
		ex_t0 = ph.t0 && ae_reg;
	end

	// Next state of the datapath registers and the load machine.
	always_comb begin
		pc_next = pc_reg;
		ma_next = ma_reg;
		x_next = x_reg;
		opc_next = opc_reg;
		ae_next = ae_reg;
		add_next = 1'b0;
		rd_pend_next = 1'b0;
		st_next = st_reg;
		if (ph.last) begin
			ae_next = !ae_reg; // [RULE1] [RULE9] [RULE16]
		end
		// Even word holds the opcode, odd word the operand. [RULE18]
		if (acq_t0) begin
			case (ph.step)
				`FES_DP_PC2MA: ma_next = pc_reg; // [RULE3]
				`FES_DP_RD_OPC,
				`FES_DP_RD_OPND: rd_pend_next = 1'b1;
				`FES_DP_OPC2X,
				`FES_DP_OPND2X: x_next = mem_rdata_i; // [RULE12]
				`FES_DP_X2OPC: opc_next = x_reg; // [RULE4]
				`FES_DP_MA_INC: ma_next = ma_reg + `FES_MA_STEP; // [RULE5]
				`FES_DP_X2MA: ma_next = x_reg; // [RULE2] [RULE6]
				`FES_DP_PC_ADV: pc_next = pc_reg + `FES_PC_STEP; // [RULE7]
				default: ;
			endcase
		end
		if (ex_t0 && cmd.valid) begin
			case (opc_reg)
				`FES_OPC_ADD: begin
					if (ph.step == `FES_DP_EX_RD) begin
						rd_pend_next = 1'b1;
					end
					if (ph.step == `FES_DP_EX_X) begin
						x_next = mem_rdata_i; // [RULE8] [RULE12]
					end
					add_next = (ph.step == `FES_DP_EX_ADD); // [RULE8]
				end
				`FES_OPC_JUMP: begin
					if (ph.step == `FES_DP_EX_RD) begin
						pc_next = ma_reg; // Replaces the advanced PC. [RULE7]
					end
				end
				`FES_OPC_LOAD: begin
					if (ph.step == `FES_DP_EX_RD) begin
						st_next = fes_pkg::FES_ST_LOAD; // [RULE11]
					end
				end
				default: ;
			endcase
		end
		// Loading holds the phase counter; addresses come from here.
		case (st_reg)
			fes_pkg::FES_ST_RUN: ;
			fes_pkg::FES_ST_LOAD: begin
				if (load_valid_i) begin
					x_next = load_data_i; // [RULE12]
					st_next = fes_pkg::FES_ST_WR;
				end
			end
			fes_pkg::FES_ST_WR: begin
				ma_next = ma_reg + `FES_MA_STEP; // [RULE10]
				st_next = last_reg ? fes_pkg::FES_ST_RUN
				                   : fes_pkg::FES_ST_LOAD; // [RULE11]
			end
			default: st_next = fes_pkg::FES_ST_RUN;
		endcase
	end

	// Remembers whether the word being written closes the load.
	always_comb begin
		last_next = last_reg;
		if ((st_reg == fes_pkg::FES_ST_LOAD) && load_valid_i) begin
			last_next = load_last_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pc_reg      <= `FES_RST_WORD;
			ma_reg      <= `FES_RST_WORD;
			x_reg       <= `FES_RST_WORD;
			opc_reg     <= `FES_RST_WORD;
			ae_reg      <= 1'b0; // [RULE17]
			add_reg     <= 1'b0;
			rd_pend_reg <= 1'b0;
			last_reg    <= 1'b0;
			st_reg      <= fes_pkg::FES_ST_RUN; // [RULE17]
		end else begin
			pc_reg      <= pc_next;
			ma_reg      <= ma_next;
			x_reg       <= x_next;
			opc_reg     <= opc_next;
			ae_reg      <= ae_next;
			add_reg     <= add_next;
			rd_pend_reg <= rd_pend_next;
			last_reg    <= last_next;
			st_reg      <= st_next;
		end
	end

	// The read strobe trails its step by one cycle so the address
	// register has settled on the same step's update.
	assign ph.hold      = (st_reg != fes_pkg::FES_ST_RUN);
	assign mem_addr_o   = ma_reg;
	assign mem_rd_o     = rd_pend_reg;
	assign mem_wr_o     = (st_reg == fes_pkg::FES_ST_WR); // [RULE10]
	assign mem_wdata_o  = x_reg; // Only the exchange feeds memory. [RULE12]
	assign add_o        = add_reg;
	assign xchg_o       = x_reg;
	assign ae_o         = ae_reg;
	assign opcode_o     = opc_reg;
	assign cmd_valid_o  = cmd.valid;
	assign cmd_idx_o    = cmd.idx;
	assign step_o       = ph.step;
	assign load_ready_o = (st_reg == fes_pkg::FES_ST_LOAD);

	a_acq_blocks_decode: assert property (@(posedge clk_i) // [RULE14]
		disable iff (rst_i) !ae_o |-> !cmd_valid_o)
		else $error("command decoded during acquisition");

	a_flag_sets_exec: assert property (@(posedge clk_i) // [RULE1]
		disable iff (rst_i)
		(ph.last && !ae_o) |=> ae_o && (step_o == 4'h0))
		else $error("execution did not follow acquisition");

	a_flag_returns_acq: assert property (@(posedge clk_i) // [RULE9]
		disable iff (rst_i) (ph.last && ae_o) |=> !ae_o)
		else $error("acquisition did not follow execution");

	a_pc_to_addr: assert property (@(posedge clk_i) // [RULE3]
		disable iff (rst_i) (acq_t0 && (ph.step == 4'h0)) |=>
		(mem_addr_o == $past(pc_reg)))
		else $error("address register missed the PC");

	// Each hop of a fetched word is checked on its own step, so the
	// check does not depend on the step period.
	a_x_from_mem: assert property (@(posedge clk_i) // [RULE12]
		disable iff (rst_i)
		(acq_t0 && ((ph.step == 4'h2) || (ph.step == 4'h6))) |=>
		(xchg_o == $past(mem_rdata_i)))
		else $error("read word not captured in exchange");

	a_opcode_via_x: assert property (@(posedge clk_i) // [RULE4]
		disable iff (rst_i) (acq_t0 && (ph.step == 4'h3)) |=>
		(opcode_o == $past(xchg_o)))
		else $error("opcode not loaded from exchange");

	a_addr_odd_step: assert property (@(posedge clk_i) // [RULE5]
		disable iff (rst_i) (acq_t0 && (ph.step == 4'h4)) |=>
		(mem_addr_o == 6'($past(mem_addr_o) + 6'h01)))
		else $error("address register not advanced by one");

	a_operand_loaded: assert property (@(posedge clk_i) // [RULE6]
		disable iff (rst_i) (acq_t0 && (ph.step == 4'h7)) |=>
		(mem_addr_o == xchg_o))
		else $error("operand address not in address register");

	a_pc_advance: assert property (@(posedge clk_i) // [RULE7]
		disable iff (rst_i) (acq_t0 && (ph.step == 4'h8)) |=>
		(pc_reg == 6'($past(pc_reg) + 6'h02)))
		else $error("PC did not advance to next pair");

	a_add_cause: assert property (@(posedge clk_i) // [RULE8]
		disable iff (rst_i)
		add_o |-> ae_o && (opcode_o == 6'h28) && (step_o == 4'h4))
		else $error("add pulse without add instruction");

	a_load_addr_gen: assert property (@(posedge clk_i) // [RULE10]
		disable iff (rst_i) mem_wr_o |=> !mem_wr_o &&
		(mem_addr_o == 6'($past(mem_addr_o) + 6'h01)))
		else $error("load address not generated internally");

	a_load_through_x: assert property (@(posedge clk_i) // [RULE12]
		disable iff (rst_i) (load_ready_o && load_valid_i) |=>
		mem_wr_o && (mem_wdata_o == $past(load_data_i)))
		else $error("loaded word bypassed exchange");

	a_load_holds: assert property (@(posedge clk_i) // [RULE11]
		disable iff (rst_i)
		(load_ready_o && load_valid_i && !load_last_i) |=> ##1
		load_ready_o)
		else $error("load ended before last word");

	c_add_seen: cover property (@(posedge clk_i) disable iff (rst_i) add_o);
	c_jump_seen: cover property (@(posedge clk_i) disable iff (rst_i)
		ex_t0 && (opcode_o == 6'h0b) && (step_o == 4'h1));
	c_load_end: cover property (@(posedge clk_i) disable iff (rst_i)
		mem_wr_o && last_reg);
	c_full_cycle: cover property (@(posedge clk_i) disable iff (rst_i)
		ph.last && ae_o);

endmodule

// ### fes_params.svh
// Constants of the fetch/execute sequencer: widths, phase steps, opcodes
// and timing. Included by the package, the sequencer and the phase counter.
`ifndef FES_PARAMS_SVH
`define FES_PARAMS_SVH

// Data and address width of the machine word.
`define FES_WORD_W       6
// Phase counter width and its last step (octal 17).
`define FES_PHASE_W      4
`define FES_PHASE_LAST   4'hf

// Acquisition steps.
`define FES_DP_PC2MA     4'h0
`define FES_DP_RD_OPC    4'h1
`define FES_DP_OPC2X     4'h2
`define FES_DP_X2OPC     4'h3
`define FES_DP_MA_INC    4'h4
`define FES_DP_RD_OPND   4'h5
`define FES_DP_OPND2X    4'h6
`define FES_DP_X2MA      4'h7
`define FES_DP_PC_ADV    4'h8

// Execution steps.
`define FES_DP_EX_RD     4'h1
`define FES_DP_EX_X      4'h2
`define FES_DP_EX_ADD    4'h3

// Program counter step: one instruction is an even/odd word pair.
`define FES_PC_STEP      6'h02
`define FES_MA_STEP      6'h01
`define FES_RST_WORD     6'h00

// Opcodes acted on here; they and every other decodable opcode go out as decoded commands.
`define FES_OPC_ADD      6'h28
`define FES_OPC_JUMP     6'h0b
`define FES_OPC_LOAD     6'h2e

// Decoder size: basic codes and odd variants.
`define FES_N_BASIC      5'h18
`define FES_N_VARIANT    5'h06

// Timing pulse period and clock period.
`define FES_T0_PERIOD_US 50
`define FES_CLK_PERIOD_NS 4
`define FES_T0_CYC       (`FES_T0_PERIOD_US * 1000 / `FES_CLK_PERIOD_NS)
`define FES_DIV_W        16

`endif

// ### fes_pkg.sv
// Types shared by the sequencer modules.
// Assumes fes_params.svh is on the include path.
`include "fes_params.svh"

package fes_pkg;

	typedef logic [`FES_WORD_W-1:0] fes_word_t;
	typedef logic [`FES_PHASE_W-1:0] fes_phase_t;

	typedef enum logic [1:0] {
		FES_ST_RUN  = 2'b00,
		FES_ST_LOAD = 2'b01,
		FES_ST_WR   = 2'b10
	} fes_state_t;

	typedef struct packed {
		logic       valid;
		logic [4:0] idx;
	} fes_cmd_t;

endpackage

// ### fes_phase_if.sv
// Link between the sequencer core and its phase counter.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps

interface fes_phase_if;
	logic              hold;
	logic              t0;
	logic              last;
	fes_pkg::fes_phase_t step;

	modport ctl (output hold, input t0, input last, input step);
	modport seq (input hold, output t0, output last, output step);
endinterface

// ### fes_phase.sv
// Timing pulse divider and 4-bit phase counter.
// Assumes a synchronous active-high reset and one clock.
`timescale 1ns/1ps
`include "fes_params.svh"

module fes_phase #(
	parameter int unsigned T0_CYC = `FES_T0_CYC
) (
	// Clock and reset.
	input  wire logic clk_i,
	input  wire logic rst_i,
	// Phase link.
	fes_phase_if.seq  ph
);

	// Only the low bits of the last count are kept; the width covers the
	// full divide ratio, so nothing of value is cut.
	localparam int unsigned DIV_LAST_I = T0_CYC - 1;
	localparam logic [`FES_DIV_W-1:0] DIV_LAST = DIV_LAST_I[`FES_DIV_W-1:0];

	logic [`FES_DIV_W-1:0] div_reg;
	logic [`FES_DIV_W-1:0] div_next;
	fes_pkg::fes_phase_t   step_reg;
	fes_pkg::fes_phase_t   step_next;
	logic                  tick;

	// The divider runs free; a held sequencer simply lets ticks pass.
	always_comb begin
		tick = (div_reg == DIV_LAST);
		div_next = tick ? '0 : div_reg + 1'b1;
		step_next = step_reg;
		if (tick && !ph.hold) begin
			step_next = step_reg + 1'b1; // Wraps 17 to 0. [RULE16]
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			div_reg  <= '0;
			step_reg <= '0; // [RULE17]
		end else begin
			div_reg  <= div_next;
			step_reg <= step_next;
		end
	end

	// One pulse per step, withheld while held.
	assign ph.t0   = tick && !ph.hold;
	assign ph.step = step_reg;
	assign ph.last = ph.t0 && (step_reg == `FES_PHASE_LAST); // [RULE16]

	a_phase_wrap: assert property (@(posedge clk_i) // [RULE16]
		disable iff (rst_i) ph.last |=> (ph.step == 4'h0))
		else $error("phase counter did not clear after last step");

	a_phase_step: assert property (@(posedge clk_i) // [RULE16]
		disable iff (rst_i) (ph.t0 && !ph.last) |=>
		(ph.step == 4'($past(ph.step) + 1'b1)))
		else $error("phase counter did not advance by one");

	a_hold_freeze: assert property (@(posedge clk_i) // [RULE16]
		disable iff (rst_i) ph.hold |=> $stable(ph.step))
		else $error("phase counter moved while held");

endmodule

// ### fes_mem_model.sv
// Behavioural memory and arithmetic section facing the sequencer.
// Assumes the sequencer clock and that read data is needed for T0_CYC
// cycles after the read strobe, then the bus no longer holds it.
`timescale 1ns/1ps

module fes_mem_model #(
	parameter int unsigned T0_CYC = 4
) (
	// Clock.
	input  wire logic       clk_i,
	// Memory port.
	input  wire logic [5:0] addr_i,
	input  wire logic       rd_i,
	input  wire logic       wr_i,
	input  wire logic [5:0] wdata_i,
	output logic [5:0]      rdata_o,
	// Arithmetic port.
	input  wire logic       add_i,
	input  wire logic [5:0] xchg_i,
	output logic [5:0]      acc_o
);
	logic [5:0] mem [64];
	int         hold_cnt;

	initial begin
		rdata_o  = 6'h15;
		acc_o    = 6'h00;
		hold_cnt = 0;
	end

	// Reads hold their data only for one step, then the bus shows the
	// inverse so that a late sample can never look like a match.
	always @(posedge clk_i) begin
		if (wr_i) begin
			mem[addr_i] <= wdata_i;
		end
		if (rd_i) begin
			rdata_o  <= mem[addr_i];
			hold_cnt <= T0_CYC;
		end else if (hold_cnt > 1) begin
			hold_cnt <= hold_cnt - 1;
		end else if (hold_cnt == 1) begin
			rdata_o  <= ~rdata_o;
			hold_cnt <= 0;
		end
		if (add_i) begin
			acc_o <= acc_o + xchg_i;
		end
	end
endmodule

// ### fes_sequencer_tb.sv
// Self-checking bench for the sequencer with a tiny loaded program.
// Assumes fes_pkg, fes_phase_if and fes_phase are compiled before it.
`timescale 1ns/1ps

module fes_sequencer_tb;
	localparam int unsigned T0 = 4;

	logic       clk_i = 1'b0;
	logic       rst_i = 1'b1;
	logic [5:0] mem_addr_o, mem_wdata_o, mem_rdata_i, xchg_o, opcode_o;
	logic       mem_rd_o, mem_wr_o, add_o, ae_o, cmd_valid_o, load_ready_o;
	logic [4:0] cmd_idx_o;
	logic [3:0] step_o;
	logic       load_valid_i = 1'b0;
	logic       load_last_i  = 1'b0;
	logic [5:0] load_data_i  = 6'h00;
	logic [5:0] acc;
	logic [5:0] rd_q[$];
	logic [5:0] add_q[$];
	int         error_cnt    = 0;
	int         total_checks = 0;

	fes_sequencer #(.T0_CYC(T0)) DUT (
		.clk_i(clk_i), .rst_i(rst_i), .mem_addr_o(mem_addr_o),
		.mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o),
		.mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i),
		.add_o(add_o), .xchg_o(xchg_o), .ae_o(ae_o), .opcode_o(opcode_o),
		.cmd_valid_o(cmd_valid_o), .cmd_idx_o(cmd_idx_o), .step_o(step_o),
		.load_valid_i(load_valid_i), .load_data_i(load_data_i),
		.load_last_i(load_last_i), .load_ready_o(load_ready_o));

	fes_mem_model #(.T0_CYC(T0)) mem_u (
		.clk_i(clk_i), .addr_i(mem_addr_o), .rd_i(mem_rd_o),
		.wr_i(mem_wr_o), .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i),
		.add_i(add_o), .xchg_i(xchg_o), .acc_o(acc));

	// Clock at 250 MHz.
	always #2 clk_i = ~clk_i;

	// Logs read addresses and add operands; decode must stay quiet while
	// the sequencer is still acquiring.
	always @(negedge clk_i) begin
		if (mem_rd_o === 1'b1) rd_q.push_back(mem_addr_o);
		if (add_o === 1'b1) add_q.push_back(xchg_o);
		if (!rst_i && ae_o === 1'b0 && cmd_valid_o !== 1'b0) begin
			error_cnt++;
			$display("unexpected at %0t: command during fetch", $time);
		end
	end

	task automatic chk(input logic ok, input string msg);
		total_checks++;
		if (ok !== 1'b1) begin
			error_cnt++;
			$display("unexpected at %0t: %s", $time, msg);
		end
	endtask

	task automatic complete_run();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Waits, bounded, for the phase flag to reach a value.
	task automatic wait_ae(input logic v);
		int n;
		n = 0;
		while (ae_o !== v && n < 400) begin
			@(negedge clk_i);
			n++;
		end
		chk(ae_o === v, "phase flag did not change");
	endtask

	task automatic test_reset();
		@(negedge clk_i);
		chk(ae_o === 1'b0 && step_o === 4'h0, "reset phase state");
		chk(mem_rd_o === 1'b0 && mem_wr_o === 1'b0, "reset strobes");
		chk(load_ready_o === 1'b0 && add_o === 1'b0, "reset idle");
	endtask

	// First fetch: the load instruction at address zero.
	task automatic test_fetch();
		rd_q.delete();
		wait_ae(1'b1);
		chk(rd_q.size() == 2, "fetch read count");
		chk(rd_q[0] === 6'h00, "opcode from counter");
		chk(rd_q[1] === 6'h01, "operand at odd word");
		chk(opcode_o === 6'h2e, "opcode register");
		chk(mem_addr_o === 6'h02, "operand address");
		chk(step_o === 4'h0, "counter cleared");
		@(negedge clk_i);
		chk(cmd_valid_o === 1'b1 && cmd_idx_o === 5'd23, "load cmd");
	endtask

	// External load of six words at the operand address; the counter
	// stays put while words arrive.
	task automatic test_load();
		logic [5:0] w [6];
		logic [3:0] s;
		int         n;
		w = '{6'h28, 6'h20, 6'h28, 6'h21, 6'h0b, 6'h02};
		s = 4'h0;
		for (int i = 0; i < 6; i++) begin
			n = 0;
			while (load_ready_o !== 1'b1 && n < 400) begin
				@(negedge clk_i);
				n++;
			end
			chk(load_ready_o === 1'b1, "load not ready");
			if (i == 0) s = step_o;
			chk(step_o === s, "counter moved in load");
			@(posedge clk_i);
			load_valid_i <= 1'b1;
			load_data_i  <= w[i];
			load_last_i  <= (i == 5);
			@(posedge clk_i);
			load_valid_i <= 1'b0;
			load_last_i  <= 1'b0;
			#1;
			chk(mem_wr_o === 1'b1, "no write strobe");
			chk(mem_addr_o === 6'h02 + 6'(i), "store address");
			chk(mem_wdata_o === w[i], "store data");
		end
		@(negedge clk_i);
		@(negedge clk_i);
		chk(load_ready_o === 1'b0, "load did not end");
		for (int i = 0; i < 6; i++) begin
			chk(mem_u.mem[2+i] === w[i], "stored word");
		end
	endtask

	// One instruction: fetch at pc, decode, then execute; an add reads
	// its operand and sums it, a jump does no memory work.
	task automatic test_instr(input logic [5:0] pc, input logic [4:0] idx,
			input logic is_add, input logic [5:0] opnd,
			input logic [5:0] val, input logic [5:0] acc_exp);
		rd_q.delete();
		wait_ae(1'b0);
		wait_ae(1'b1);
		chk(rd_q.size() == 2 && rd_q[0] === pc, "fetch address");
		chk(rd_q[1] === pc + 6'h01, "operand fetch");
		@(negedge clk_i);
		chk(cmd_valid_o === 1'b1 && cmd_idx_o === idx, "decode");
		rd_q.delete();
		add_q.delete();
		wait_ae(1'b0);
		if (is_add) begin
			chk(rd_q.size() == 1 && rd_q[0] === opnd, "add read");
			chk(add_q.size() == 1 && add_q[0] === val, "add data");
			chk(acc === acc_exp, "accumulator");
		end else begin
			chk(rd_q.size() == 0 && add_q.size() == 0, "jump idle");
		end
	endtask

	// Main sequence: program image, reset, then the scenarios.
	initial begin
		for (int i = 0; i < 64; i++) mem_u.mem[i] = 6'h3f;
		mem_u.mem[0]     = 6'h2e;
		mem_u.mem[1]     = 6'h02;
		mem_u.mem[6'h20] = 6'h05;
		mem_u.mem[6'h21] = 6'h07;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		test_reset();
		test_fetch();
		test_load();
		test_instr(6'h02, 5'd20, 1'b1, 6'h20, 6'h05, 6'h05);
		test_instr(6'h04, 5'd20, 1'b1, 6'h21, 6'h07, 6'h0c);
		test_instr(6'h06, 5'd29, 1'b0, 6'h00, 6'h00, 6'h0c);
		test_instr(6'h02, 5'd20, 1'b1, 6'h20, 6'h05, 6'h11);
		complete_run();
	end

	// Watchdog: the program above needs well under a thousand cycles.
	initial begin
		repeat (5000) @(posedge clk_i);
		error_cnt++;
		$display("unexpected at %0t: watchdog expired", $time);
		complete_run();
	end
endmodule
